// file: core/vtq_pkg.sv
package vtq_pkg;

   localparam logic [11:0] VTQ_OFF_CTRL   = 12'hA00;
   localparam logic [11:0] VTQ_OFF_SEL_LO = 12'hA08;
   localparam logic [11:0] VTQ_OFF_SEL_HI = 12'hA0C;
   localparam logic [11:0] VTQ_OFF_REQ_LO = 12'hA10;
   localparam logic [11:0] VTQ_OFF_REQ_HI = 12'hA14;
   localparam logic [11:0] VTQ_OFF_RES_LO = 12'hA18;
   localparam logic [11:0] VTQ_OFF_RES_HI = 12'hA1C;

   localparam int VTQ_GO_BIT    = 0;
   localparam int VTQ_SUBV_BIT  = 20;
   localparam int VTQ_ADDR_LSB  = 12;
   localparam int VTQ_TYPE_LSB  = 10;
   localparam int VTQ_PRIV_BIT  = 9;
   localparam int VTQ_DIR_BIT   = 8;
   localparam int VTQ_FETCH_BIT = 7;
   localparam int VTQ_INHIB_BIT = 6;

   localparam logic [31:0] VTQ_REQ_LO_MASK = 32'hFFFF_FFC0;
   localparam logic [63:0] VTQ_REG_RESET   = 64'h0;
   localparam logic [1:0]  VTQ_TYPE_STAGE1 = 2'h1;
   localparam logic [1:0]  VTQ_SH_OUTER    = 2'h2;
   localparam logic [1:0]  VTQ_REASON_S1   = 2'h0;
   localparam logic [7:0]  VTQ_CODE_BADREQ = 8'h01;

   typedef struct packed {
      logic [51:0] in_addr;
      logic        privilege_flag;
      logic        access_direction;
      logic        fetch_kind;
      logic        table_update_inhibit;
      logic        override_block;
      logic        sub_stream_tag_valid;
      logic [19:0] sub_stream_tag;
      logic [31:0] requester_stream_tag;
   } vtq_query_t;

   typedef struct packed {
      logic        fault;
      logic [7:0]  mem_type_code;
      logic [43:0] out_addr;
      logic        block_size;
      logic [1:0]  coherency_domain;
      logic [7:0]  error_kind_code;
      logic [3:0]  impl_data;
   } vtq_walk_res_t;

endpackage : vtq_pkg

// file: core/vtq_result_fmt.sv
`timescale 1ns/10ps
`default_nettype none
module vtq_result_fmt
   import vtq_pkg::*;
#(
   parameter int OUT_RANGE = 48
) (
   input  wire logic          clock,
   input  wire logic          reset,
   input  wire logic          load,
   input  wire vtq_walk_res_t res,
   output var  logic [63:0]   result_r
);

   logic [43:0] oa_mask;
   logic [43:0] oa_kept;
   logic        dev_mem;
   logic [1:0]  sh_eff;
   logic [63:0] ok_word;
   logic [63:0] fault_word;
   logic [63:0] result_nxt;

   genvar i;
   generate
      for (i = 0; i < 44; i++) begin : g_oa
         assign oa_mask[i] = ((i + 12) < OUT_RANGE);
      end
   endgenerate

   // Device memory has a zero upper attribute nibble and is always outer.
   assign dev_mem    = (res.mem_type_code[7:4] == 4'h0);
   assign sh_eff     = dev_mem ? VTQ_SH_OUTER : res.coherency_domain;
   assign oa_kept    = res.out_addr & oa_mask;
   assign ok_word    = {res.mem_type_code, oa_kept, res.block_size,
                        1'h0, sh_eff, 7'h0, 1'h0};
   assign fault_word = {res.impl_data, 4'h0, 44'h0,
                        res.error_kind_code, 1'h0, VTQ_REASON_S1, 1'h1};
   assign result_nxt = res.fault ? fault_word : ok_word;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         result_r <= VTQ_REG_RESET;
      end else if (load) begin
         result_r <= result_nxt;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_fault_page_zero;
      load && res.fault |=> result_r[55:12] == 44'h0 && result_r[0];
   endproperty
   a_fault_page_zero: assert property (p_fault_page_zero)
      else $error("fault page field not zero");

   property p_reason_stage1;
      result_r[0] |-> result_r[2:1] == VTQ_REASON_S1 && result_r[3] == 1'h0;
   endproperty
   a_reason_stage1: assert property (p_reason_stage1)
      else $error("fault class not stage one");

   property p_device_outer;
      load && !res.fault && res.mem_type_code[7:4] == 4'h0
         |=> result_r[9:8] == VTQ_SH_OUTER && !result_r[0];
   endproperty
   a_device_outer: assert property (p_device_outer)
      else $error("device memory not reported outer");

endmodule : vtq_result_fmt
`default_nettype wire

// file: core/vtq_regs.sv
// Operation
// - Selector bit 52 is substream valid only if substreams exist, else zero.
// - Substream tag in 51:32; bits above supported width read zero.
// - Stream tag in 31:0; bits at or above supported width read zero.
// - Identifier bits beyond implemented range act as zero, no effect.
// - Selector and request change only while go is clear; read-only otherwise.
// - Selector decodes at 0x0A08, request at 0x0A10.
// - Request holds input address in 63:12; bits 5:0 are zero.
// - Request type must be 01; anything else finishes with bad request.
// - Request bit 9 picks unprivileged or privileged query.
// - Bit 8 read or write; bit 7 fetch kind, forced data on writes.
// - Bit 6 set inhibits table updates and any state change.
// - Privilege and fetch kind are never overridden by stream table entry.
// - Result bit 0 picks success layout or fault syndrome.
// - Success: attributes 63:56, output address 55:12, unimplemented bits zero.
// - Success bit 11 clear means 4KB, set means lowest address bit size.
// - Shareability in 9:8; device memory always reported outer.
// - Fault: impl data 63:60, code 11:4, class 2:1, others zero.
// - Fault page field always reads zero.
// - Fault class only reports 00.
// - Without the feature every read is zero and writes are ignored.
// - Software sets go after loading; device clears it when result shows.
// - Result is read-only at 0x0A18; undefined while go is set.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module vtq_regs
   import vtq_pkg::*;
#(
   parameter bit QUERY_PRESENT = 1'b1,
   parameter int SUB_WIDTH     = 20,
   parameter int STREAM_WIDTH  = 32,
   parameter int OUT_RANGE     = 48
) (
   input  wire logic          clock,
   input  wire logic          reset,
   input  wire logic [11:0]   addr,
   input  wire logic [31:0]   wr_data,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   output var  logic [31:0]   rd_data,
   output var  logic          walk_start,
   output var  vtq_query_t    walk_query,
   input  wire logic          walk_done,
   input  wire vtq_walk_res_t walk_res,
   output var  logic          query_busy
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WALK = 3'h2,
      ST_DONE = 3'h4
   } vtq_state_t;

   vtq_state_t    state_r;
   vtq_state_t    state_nxt;
   logic [63:0]   sel_r;
   logic [63:0]   req_r;
   logic          go_r;
   logic          go_nxt;
   logic [31:0]   rd_nxt;
   logic [63:0]   result;
   logic          fmt_load;
   vtq_walk_res_t fmt_res;
   vtq_walk_res_t bad_res;
   vtq_query_t    query_nxt;

   logic [31:0]   stream_mask;
   logic [19:0]   sub_mask;
   logic          sub_en;

   logic          hit_ctrl;
   logic          hit_sel_lo;
   logic          hit_sel_hi;
   logic          hit_req_lo;
   logic          hit_req_hi;
   logic          hit_res_lo;
   logic          hit_res_hi;
   logic          wr_ok;
   logic          type_ok;
   logic          launch;
   logic [31:0]   sel_lo_nxt;
   logic [31:0]   sel_hi_nxt;
   logic [31:0]   req_lo_nxt;

   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_sid
         assign stream_mask[i] = (i < STREAM_WIDTH);
         if (i < 20) begin : g_ssid
            assign sub_mask[i] = (i < SUB_WIDTH);
         end
      end
   endgenerate

   assign sub_en = (SUB_WIDTH != 0);

   // Address decode; unmapped offsets read zero and ignore writes.
   assign hit_ctrl   = (addr == VTQ_OFF_CTRL);
   assign hit_sel_lo = (addr == VTQ_OFF_SEL_LO);
   assign hit_sel_hi = (addr == VTQ_OFF_SEL_HI);
   assign hit_req_lo = (addr == VTQ_OFF_REQ_LO);
   assign hit_req_hi = (addr == VTQ_OFF_REQ_HI);
   assign hit_res_lo = (addr == VTQ_OFF_RES_LO);
   assign hit_res_hi = (addr == VTQ_OFF_RES_HI);

   // Writes land only when the feature exists and no query is running.
   assign wr_ok = wr_en && QUERY_PRESENT && !go_r;

   // Identifier bits outside the implemented range are dropped on entry,
   // so they can never reach the walker.
   assign sel_lo_nxt = wr_data & stream_mask;
   assign sel_hi_nxt = {11'h0,
                        wr_data[VTQ_SUBV_BIT] & sub_en,
                        wr_data[19:0] & sub_mask};
   assign req_lo_nxt = wr_data & VTQ_REQ_LO_MASK;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sel_r <= VTQ_REG_RESET;
      end else begin
         if (wr_ok && hit_sel_lo) begin
            sel_r[31:0] <= sel_lo_nxt;
         end
         if (wr_ok && hit_sel_hi) begin
            sel_r[63:32] <= sel_hi_nxt;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         req_r <= VTQ_REG_RESET;
      end else begin
         if (wr_ok && hit_req_lo) begin
            req_r[31:0] <= req_lo_nxt;
         end
         if (wr_ok && hit_req_hi) begin
            req_r[63:32] <= wr_data;
         end
      end
   end

   // Go is set by software only while clear and cleared by hardware only
   // while set, so the two can never collide in one cycle.
   always_comb begin
      go_nxt = go_r;
      if (wr_ok && hit_ctrl && wr_data[VTQ_GO_BIT]) begin
         go_nxt = 1'h1;
      end else if (state_r == ST_DONE) begin
         go_nxt = 1'h0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         go_r <= 1'h0;
      end else begin
         go_r <= go_nxt;
      end
   end

   assign type_ok = (req_r[VTQ_TYPE_LSB +: 2] == VTQ_TYPE_STAGE1);
   assign launch  = (state_r == ST_IDLE) && go_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (launch) begin
               state_nxt = type_ok ? ST_WALK : ST_DONE;
            end
         end
         ST_WALK: begin
            if (walk_done) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The query hands the walker the attributes as software wrote them, except that
   // fetch kind is forced to data on writes, and asks it not to apply per-stream overrides.
   assign query_nxt.in_addr              = req_r[63:VTQ_ADDR_LSB];
   assign query_nxt.privilege_flag       = req_r[VTQ_PRIV_BIT];
   assign query_nxt.access_direction     = req_r[VTQ_DIR_BIT];
   assign query_nxt.fetch_kind           = req_r[VTQ_DIR_BIT]
                                           & req_r[VTQ_FETCH_BIT];
   assign query_nxt.table_update_inhibit = req_r[VTQ_INHIB_BIT];
   assign query_nxt.override_block       = 1'h1;
   assign query_nxt.sub_stream_tag_valid = sel_r[32 + VTQ_SUBV_BIT];
   assign query_nxt.sub_stream_tag       = sel_r[51:32];
   assign query_nxt.requester_stream_tag = sel_r[31:0];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         walk_start <= 1'h0;
         walk_query <= '0;
      end else begin
         walk_start <= launch && type_ok;
         if (launch) begin
            walk_query <= query_nxt;
         end
      end
   end

   // A bad request type never reaches the walker; it is answered here.
   assign bad_res.fault            = 1'h1;
   assign bad_res.mem_type_code    = 8'h0;
   assign bad_res.out_addr         = 44'h0;
   assign bad_res.block_size       = 1'h0;
   assign bad_res.coherency_domain = 2'h0;
   assign bad_res.error_kind_code  = VTQ_CODE_BADREQ;
   assign bad_res.impl_data        = 4'h0;

   assign fmt_load = (launch && !type_ok) || (state_r == ST_WALK && walk_done);
   assign fmt_res  = (state_r == ST_WALK) ? walk_res : bad_res;

   vtq_result_fmt #(
      .OUT_RANGE (OUT_RANGE)
   ) u_fmt (
      .clock    (clock),
      .reset    (reset),
      .load     (fmt_load),
      .res      (fmt_res),
      .result_r (result)
   );

   // Reading the result while busy returns whatever it holds.
   assign rd_nxt = !QUERY_PRESENT ? 32'h0 :
                   hit_ctrl   ? {31'h0, go_r} :
                   hit_sel_lo ? sel_r[31:0] :
                   hit_sel_hi ? sel_r[63:32] :
                   hit_req_lo ? req_r[31:0] :
                   hit_req_hi ? req_r[63:32] :
                   hit_res_lo ? result[31:0] :
                   hit_res_hi ? result[63:32] :
                   32'h0;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_data    <= 32'h0;
         query_busy <= 1'h0;
      end else begin
         rd_data    <= rd_en ? rd_nxt : 32'h0;
         query_busy <= go_nxt;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_locked_while_go;
      go_r && wr_en |=> $stable(sel_r) && $stable(req_r);
   endproperty
   a_locked_while_go: assert property (p_locked_while_go)
      else $error("selector or request changed while busy");

   property p_subv_zero;
      !sub_en |-> sel_r[52] == 1'h0;
   endproperty
   a_subv_zero: assert property (p_subv_zero)
      else $error("substream valid set without substreams");

   property p_sub_range;
      (sel_r[51:32] & ~sub_mask) == 20'h0 && sel_r[63:53] == 11'h0;
   endproperty
   a_sub_range: assert property (p_sub_range)
      else $error("substream bits beyond width");

   property p_stream_range;
      (sel_r[31:0] & ~stream_mask) == 32'h0;
   endproperty
   a_stream_range: assert property (p_stream_range)
      else $error("stream bits beyond width");

   property p_req_low_zero;
      req_r[5:0] == 6'h0;
   endproperty
   a_req_low_zero: assert property (p_req_low_zero)
      else $error("reserved request bits set");

   property p_bad_type;
      launch && !type_ok |-> !walk_start [*3] ##0 (!go_r && result[0]
         && result[11:4] == VTQ_CODE_BADREQ);
   endproperty
   a_bad_type: assert property (p_bad_type)
      else $error("bad request type not answered");

   property p_write_is_data;
      walk_start && !walk_query.access_direction |-> !walk_query.fetch_kind;
   endproperty
   a_write_is_data: assert property (p_write_is_data)
      else $error("write query marked as fetch");

   property p_attrs_passed;
      walk_start |-> walk_query.override_block
         && walk_query.privilege_flag == req_r[VTQ_PRIV_BIT]
         && walk_query.table_update_inhibit == req_r[VTQ_INHIB_BIT];
   endproperty
   a_attrs_passed: assert property (p_attrs_passed)
      else $error("query attributes altered");

   property p_absent_zero;
      !QUERY_PRESENT |-> rd_data == 32'h0 && !go_r;
   endproperty
   a_absent_zero: assert property (p_absent_zero)
      else $error("absent interface not read as zero");

   property p_go_clears;
      state_r == ST_WALK && walk_done |=> go_r ##1 !go_r && $stable(result);
   endproperty
   a_go_clears: assert property (p_go_clears)
      else $error("go not cleared after result");

   property p_rd_one_cycle;
      !rd_en |=> rd_data == 32'h0;
   endproperty
   a_rd_one_cycle: assert property (p_rd_one_cycle)
      else $error("read data outside its cycle");

   // Direction is passed as written, and a write never reaches the walker as a fetch.
   property p_fetch_gated;
      walk_start |-> walk_query.access_direction == req_r[VTQ_DIR_BIT]
         && walk_query.fetch_kind == (req_r[VTQ_DIR_BIT] && req_r[VTQ_FETCH_BIT]);
   endproperty
   a_fetch_gated: assert property (p_fetch_gated)
      else $error("query direction or fetch kind altered");

   // A write aimed at the result must leave it untouched unless a result lands then.
   property p_result_ro;
      wr_en && (hit_res_lo || hit_res_hi) && !fmt_load |=> $stable(result);
   endproperty
   a_result_ro: assert property (p_result_ro)
      else $error("result changed by a write");

endmodule : vtq_regs
`default_nettype wire

// file: sim/vtq_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vtq_regs_tb
   import vtq_pkg::*;
;
   logic          clock;
   logic          reset;
   logic [11:0]   addr;
   logic [31:0]   wr_data;
   logic          wr_en;
   logic          rd_en;
   logic [31:0]   rd_data;
   logic [31:0]   rd_data_off;
   logic [31:0]   rd_data_nosub;
   logic          walk_start;
   logic          walk_start_off;
   vtq_query_t    walk_query;
   logic          walk_done;
   vtq_walk_res_t walk_res;
   logic          query_busy;
   int            fail_count;
   int            checks_done;
   int            cycles;
   int            starts;
   int            starts_off;

   // Narrow identifier widths so that the out-of-range selector bits are exercised.
   vtq_regs #(.QUERY_PRESENT(1'h1), .SUB_WIDTH(8), .STREAM_WIDTH(16), .OUT_RANGE(48)) i_vtq_regs (
      .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .walk_start(walk_start), .walk_query(walk_query),
      .walk_done(walk_done), .walk_res(walk_res), .query_busy(query_busy));

   // A second copy built without the feature sees the same traffic and must stay silent.
   vtq_regs #(.QUERY_PRESENT(1'h0)) i_vtq_regs_off (
      .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data_off), .walk_start(walk_start_off), .walk_query(),
      .walk_done(walk_done), .walk_res(walk_res), .query_busy());

   // A copy with no substreams and the full stream width sees the same traffic.
   vtq_regs #(.SUB_WIDTH(0)) i_vtq_regs_nosub (
      .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data_nosub), .walk_start(), .walk_query(),
      .walk_done(walk_done), .walk_res(walk_res), .query_busy());

   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clock) begin
      cycles++;
      if (walk_start === 1'h1) starts++;
      if (walk_start_off === 1'h1) starts_off++;
      if (cycles > 3000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'h1;
      @(posedge clock);
      wr_en   <= 1'h0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
      @(posedge clock);
      addr  <= a;
      rd_en <= 1'h1;
      @(posedge clock);
      rd_en <= 1'h0;
      #1;
      chk(name, exp, rd_data);
      chk({name, "_absent"}, 32'h0, rd_data_off);
   endtask : rd

   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (query_busy !== 1'h0 && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("busy_fall", 1'h0, query_busy);
   endtask : wait_idle

   task automatic go_check(input vtq_query_t q);
      wr(VTQ_OFF_CTRL, 32'h1);
      @(posedge clock);
      #1;
      chk("walk_start", 1'h1, walk_start);
      chk("walk_query", q, walk_query);
      chk("busy", 1'h1, query_busy);
   endtask : go_check

   task automatic walk(input vtq_walk_res_t r);
      @(posedge clock);
      walk_done <= 1'h1;
      walk_res  <= r;
      @(posedge clock);
      walk_done <= 1'h0;
      wait_idle();
   endtask : walk

   // Flags are privilege, direction, fetch kind, update inhibit, in that order.
   function automatic vtq_query_t mkq(input logic [51:0] a, input logic [3:0] f);
      vtq_query_t q;
      q.in_addr = a;
      {q.privilege_flag, q.access_direction, q.fetch_kind, q.table_update_inhibit} = f;
      q.override_block = 1'h1;
      q.sub_stream_tag_valid = 1'h1;
      q.sub_stream_tag = 20'h000FF;
      q.requester_stream_tag = 32'h0000FFFF;
      return q;
   endfunction : mkq

   logic [11:0] offs [8] = '{12'hA00, 12'hA08, 12'hA0C, 12'hA10, 12'hA14, 12'hA18, 12'hA1C,
                             12'hA20};
   logic [1:0]  bad_types [3] = '{2'h0, 2'h2, 2'h3};
   int          n0;

   initial begin
      reset = 1'h1;
      addr = 12'h0;
      wr_data = 32'h0;
      wr_en = 1'h0;
      rd_en = 1'h0;
      walk_done = 1'h0;
      walk_res = '0;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      starts = 0;
      starts_off = 0;
      repeat (6) @(posedge clock);
      reset <= 1'h0;
      foreach (offs[i]) rd(offs[i], 32'h0, "reset_read");
      $display("test reset_values done");

      wr(VTQ_OFF_SEL_LO, 32'hFFFFFFFF);
      wr(VTQ_OFF_SEL_HI, 32'hFFFFFFFF);
      rd(VTQ_OFF_SEL_LO, 32'h0000FFFF, "sel_lo");
      chk("sel_lo_full", 32'hFFFFFFFF, rd_data_nosub);
      rd(VTQ_OFF_SEL_HI, 32'h001000FF, "sel_hi");
      chk("sel_hi_nosub", 32'h0, rd_data_nosub);
      wr(VTQ_OFF_REQ_LO, 32'hFFFFFFFF);
      rd(VTQ_OFF_REQ_LO, 32'hFFFFFFC0, "req_lo");
      wr(VTQ_OFF_REQ_HI, 32'h00000ABC);
      rd(VTQ_OFF_REQ_HI, 32'h00000ABC, "req_hi");
      wr(VTQ_OFF_RES_LO, 32'hFFFFFFFF);
      wr(12'hA24, 32'hFFFFFFFF);
      rd(VTQ_OFF_RES_LO, 32'h0, "res_read_only");
      rd(12'hA24, 32'h0, "unmapped");
      $display("test register_access done");

      wr(VTQ_OFF_REQ_LO, 32'h123457C0);
      go_check(mkq({32'h00000ABC, 20'h12345}, 4'hF));
      wr(VTQ_OFF_SEL_LO, 32'h0);
      wr(VTQ_OFF_REQ_LO, 32'h0);
      wr(VTQ_OFF_CTRL, 32'h0);
      rd(VTQ_OFF_SEL_LO, 32'h0000FFFF, "sel_locked");
      rd(VTQ_OFF_REQ_LO, 32'h123457C0, "req_locked");
      rd(VTQ_OFF_CTRL, 32'h1, "go_held");
      walk({1'h0, 8'h44, 44'hBCD_EF01_2345, 1'h1, 2'h3, 8'h00, 4'h0});
      rd(VTQ_OFF_CTRL, 32'h0, "go_cleared");
      rd(VTQ_OFF_RES_LO, 32'h12345B00, "ok_lo");
      rd(VTQ_OFF_RES_HI, 32'h4400DEF0, "ok_hi");
      // A completion with no query running must leave the result alone.
      walk({1'h1, 8'hFF, 44'h0, 1'h0, 2'h0, 8'hFF, 4'hF});
      rd(VTQ_OFF_RES_LO, 32'h12345B00, "stray_done");
      $display("test read_query done");

      wr(VTQ_OFF_REQ_LO, 32'h00001480);
      go_check(mkq({32'h00000ABC, 20'h00001}, 4'h0));
      walk({1'h0, 8'h04, 44'h0, 1'h0, 2'h0, 8'h00, 4'h0});
      rd(VTQ_OFF_RES_LO, 32'h00000200, "device_lo");
      rd(VTQ_OFF_RES_HI, 32'h04000000, "device_hi");
      $display("test write_query done");

      wr(VTQ_OFF_REQ_LO, 32'h00001400);
      go_check(mkq({32'h00000ABC, 20'h00001}, 4'h0));
      walk({1'h1, 8'hFF, 44'hBCD_EF01_2345, 1'h1, 2'h3, 8'h5A, 4'hA});
      rd(VTQ_OFF_RES_LO, 32'h000005A1, "fault_lo");
      rd(VTQ_OFF_RES_HI, 32'hA0000000, "fault_hi");
      $display("test fault_query done");

      foreach (bad_types[i]) begin
         wr(VTQ_OFF_REQ_LO, {20'h00001, bad_types[i], 10'h0});
         n0 = starts;
         wr(VTQ_OFF_CTRL, 32'h1);
         wait_idle();
         chk("no_walk", n0, starts);
         rd(VTQ_OFF_RES_LO, {20'h0, VTQ_CODE_BADREQ, 4'h1}, "bad_type");
      end
      chk("walk_count", 32'h3, starts);
      chk("absent_walks", 32'h0, starts_off);
      $display("test bad_request done");
      report_and_stop();
   end
endmodule : vtq_regs_tb
`default_nettype wire
